// ### verilog/apf_ctrl.sv
// Control and status registers of an accelerometer, with sample queue.
// Assumes an APB master on clk; irq pins arrive asynchronously from outside.
// Notes on behaviour
// - Power bit 7 selects fast two-wire mode
// - Power bit 5 selects impact wake level
// - Bit 4 picks 370 or 16 ms settle
// - Power bit 3 bypasses low-pass filter
// - Power bit 2 bypasses high-pass filter
// - Mode field picks four modes, resets standby
// - Writing self check bit starts/clears run
// - Complete and pass bits read-only, reset zero
// - Code 0x52 to reset register resets all
// - Queue read pops sample, MSB byte first
// - Continued queue reads pop every third read
// - Burst started at queue keeps pointer fixed
// - Burst reaching queue returns zero, advances
// - Outside clock on pin one sets timing
// - Pin two edge produces one sample
// - Timing bits 1 and 0, reset zero
`timescale 1ns/1ps
module apf_ctrl #(
    parameter int unsigned SETTLE_LONG_CYC = apf_pkg::SETTLE_LONG_CYC,
    parameter int unsigned SETTLE_SHORT_CYC = apf_pkg::SETTLE_SHORT_CYC,
    parameter int unsigned TICK_CYC = apf_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [apf_pkg::ADDR_W-1:0] paddr,
    input wire logic [apf_pkg::DATA_W-1:0] pwdata,
    output logic [apf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins used as timing inputs
    input wire logic irq_pin_one,
    input wire logic irq_pin_two,
    // Sensor front end
    input wire logic [apf_pkg::SAMPLE_W-1:0] adc_sample,
    input wire logic self_check_ok,
    // Control and status to the sensor path
    output apf_pkg::apf_power_t power_and_mode_control,
    output logic outside_clock_enable,
    output logic outside_trigger_enable,
    output logic filter_settled,
    output apf_pkg::apf_check_t self_check_status,
    output logic sample_dropped
);
    localparam logic [apf_pkg::SETTLE_W-1:0] SETTLE_LONG_LAST =
        apf_pkg::SETTLE_W'(SETTLE_LONG_CYC - 1);
    localparam logic [apf_pkg::SETTLE_W-1:0] SETTLE_SHORT_LAST =
        apf_pkg::SETTLE_W'(SETTLE_SHORT_CYC - 1);
    localparam logic [apf_pkg::TICK_W-1:0] TICK_LAST = apf_pkg::TICK_W'(TICK_CYC - 1);

    logic rst;
    logic soft_rst_r;
    logic pready_r;
    logic pslverr_r;
    logic [apf_pkg::DATA_W-1:0] prdata_r;
    apf_pkg::apf_power_t pwr_r;
    apf_pkg::apf_power_t wpow;
    logic [1:0] tim_r;
    logic st_go_r;
    logic self_check_complete_r;
    logic st_pass_r;
    logic [6:0] st_cnt_r;
    logic [apf_pkg::SETTLE_W-1:0] settle_cnt_r;
    logic settled_r;
    logic [2:0] p1_q;
    logic [2:0] p2_q;
    logic p1_rise;
    logic p2_rise;
    logic [apf_pkg::TICK_W-1:0] div_cnt_r;
    logic div_tick_r;
    logic base_tick;
    logic sample_evt;
    logic pend_r;
    logic [apf_pkg::SAMPLE_W-1:0] pend_data_r;
    logic drop_r;
    logic take;
    logic q_in_ready;
    logic q_valid;
    logic [apf_pkg::SAMPLE_W-1:0] q_data;
    logic q_pop;
    logic q_rd;
    logic [apf_pkg::SAMPLE_W-1:0] hold_r;
    apf_pkg::apf_phase_t phase_r;
    logic [7:0] bptr_r;
    logic bfix_r;
    logic [7:0] idx;
    logic [7:0] sel_idx;
    logic aligned;
    logic mapped;
    logic access;
    logic wr;
    logic rd;
    logic queue_path;
    logic skip_zero;
    logic [7:0] reg_byte;
    logic [7:0] queue_byte;
    logic [7:0] rd_byte;

    assign rst = srst | soft_rst_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign power_and_mode_control = pwr_r;
    assign outside_clock_enable = tim_r[apf_pkg::TIM_XCLK_BIT];
    assign outside_trigger_enable = tim_r[apf_pkg::TIM_XTRIG_BIT];
    assign filter_settled = settled_r;
    assign self_check_status = '{self_check_pass: st_pass_r,
                                 self_check_complete: self_check_complete_r,
                                 self_check_go: st_go_r};
    assign sample_dropped = drop_r;

    // Address decode
    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign access = psel & penable & ~pready_r;
    assign wr = access & pwrite & mapped;
    assign rd = access & ~pwrite & mapped;
    assign wpow = apf_pkg::apf_power_t'(pwdata[7:0]);

    always_comb begin
        mapped = 1'b0;
        if (aligned) begin
            case (idx)
                apf_pkg::IDX_TIMING, apf_pkg::IDX_POWER, apf_pkg::IDX_SELF,
                apf_pkg::IDX_RESET, apf_pkg::IDX_QUEUE, apf_pkg::IDX_BADDR,
                apf_pkg::IDX_BDATA: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // Burst window reads the register under the pointer
    assign sel_idx = (idx == apf_pkg::IDX_BDATA) ? bptr_r : idx;
    assign queue_path = (idx == apf_pkg::IDX_QUEUE) ||
        ((idx == apf_pkg::IDX_BDATA) && (bptr_r == apf_pkg::IDX_QUEUE) && bfix_r);
    assign skip_zero = (idx == apf_pkg::IDX_BDATA) && (bptr_r == apf_pkg::IDX_QUEUE) && !bfix_r;
    assign q_rd = rd & queue_path;
    assign q_pop = q_rd & (phase_r == apf_pkg::PH_MSB) & q_valid;

    always_comb begin
        case (sel_idx)
            apf_pkg::IDX_TIMING: reg_byte = {6'h00, tim_r};
            apf_pkg::IDX_POWER: reg_byte = pwr_r;
            apf_pkg::IDX_SELF: reg_byte = {5'h00, st_pass_r, self_check_complete_r, st_go_r};
            default: reg_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (phase_r)
            apf_pkg::PH_MSB: queue_byte = q_valid ? q_data[15:8] : 8'h00;
            apf_pkg::PH_LSB: queue_byte = hold_r[7:0];
            default: queue_byte = 8'h00;
        endcase
    end

    always_comb begin
        if (!mapped) begin
            rd_byte = 8'h00;
        end else if (idx == apf_pkg::IDX_BADDR) begin
            rd_byte = bptr_r;
        end else if (queue_path) begin
            rd_byte = queue_byte;
        end else if (skip_zero) begin
            rd_byte = 8'h00;
        end else begin
            rd_byte = reg_byte;
        end
    end

    // APB answer, one wait state
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= access;
            pslverr_r <= access & ~mapped;
            if (access & ~pwrite) begin
                prdata_r <= {24'h000000, rd_byte};
            end
        end
    end

    // Soft reset only on the exact code
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr && (idx == apf_pkg::IDX_RESET) &&
                (pwdata[7:0] == apf_pkg::RESET_CODE);
        end
    end

    // Power and mode control
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_r <= apf_pkg::apf_power_t'(apf_pkg::REG_RST);
        end else if (wr && (idx == apf_pkg::IDX_POWER)) begin
            pwr_r <= wpow;
            pwr_r.rsvd <= 1'b0;
        end
    end

    // Timing enables
    always_ff @(posedge clk) begin
        if (rst) begin
            tim_r <= apf_pkg::TIM_RST;
        end else if (wr && (idx == apf_pkg::IDX_TIMING)) begin
            tim_r <= pwdata[1:0];
        end
    end

    // Self check run
    always_ff @(posedge clk) begin
        if (rst) begin
            st_go_r <= 1'b0;
            self_check_complete_r <= 1'b0;
            st_pass_r <= 1'b0;
            st_cnt_r <= '0;
        end else if (wr && (idx == apf_pkg::IDX_SELF)) begin
            st_go_r <= pwdata[apf_pkg::SC_GO_BIT];
            if (pwdata[apf_pkg::SC_GO_BIT]) begin
                self_check_complete_r <= 1'b0;
                st_pass_r <= 1'b0;
                st_cnt_r <= '0;
            end
        end else if (st_go_r && !self_check_complete_r) begin
            if (st_cnt_r == apf_pkg::SC_LAST) begin
                self_check_complete_r <= 1'b1;
                st_pass_r <= self_check_ok;
            end else begin
                st_cnt_r <= st_cnt_r + 7'h01;
            end
        end
    end

    // Filter settling after any power write
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_cnt_r <= '0;
            settled_r <= 1'b0;
        end else if (wr && (idx == apf_pkg::IDX_POWER)) begin
            settle_cnt_r <= wpow.settle_short ? SETTLE_SHORT_LAST : SETTLE_LONG_LAST;
            settled_r <= 1'b0;
        end else if (pwr_r.mode == apf_pkg::MODE_STANDBY) begin
            settled_r <= 1'b0;
        end else if (settle_cnt_r != '0) begin
            settle_cnt_r <= settle_cnt_r - 1'b1;
        end else begin
            settled_r <= 1'b1;
        end
    end

    // Pin synchronisers, third stage for edges
    always_ff @(posedge clk) begin
        if (srst) begin
            p1_q <= 3'h0;
            p2_q <= 3'h0;
        end else begin
            p1_q <= {p1_q[1:0], irq_pin_one};
            p2_q <= {p2_q[1:0], irq_pin_two};
        end
    end
    assign p1_rise = p1_q[1] & ~p1_q[2];
    assign p2_rise = p2_q[1] & ~p2_q[2];

    // Internal sample rate divider
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_r <= '0;
            div_tick_r <= 1'b0;
        end else if (div_cnt_r == TICK_LAST) begin
            div_cnt_r <= '0;
            div_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
            div_tick_r <= 1'b0;
        end
    end

    assign base_tick = tim_r[apf_pkg::TIM_XCLK_BIT] ? p1_rise : div_tick_r;
    assign sample_evt = (tim_r[apf_pkg::TIM_XTRIG_BIT] ? p2_rise : base_tick) &&
        (pwr_r.mode != apf_pkg::MODE_STANDBY) && settled_r;
    assign take = pend_r & q_in_ready;

    // One pending sample; stalls while the queue is full
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            pend_data_r <= '0;
            drop_r <= 1'b0;
        end else begin
            if (sample_evt && (!pend_r || take)) begin
                pend_r <= 1'b1;
                pend_data_r <= adc_sample;
            end else if (take) begin
                pend_r <= 1'b0;
            end
            if (sample_evt && pend_r && !take) begin
                drop_r <= 1'b1;
            end
        end
    end

    apf_fifo #(
        .WIDTH(apf_pkg::SAMPLE_W),
        .DEPTH(apf_pkg::QUEUE_DEPTH)
    ) u_queue (
        .clk(clk),
        .rst(rst),
        .in_valid(pend_r),
        .in_ready(q_in_ready),
        .in_data(pend_data_r),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .out_data(q_data)
    );

    // Byte phase of the queue port and held sample
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= apf_pkg::PH_MSB;
            hold_r <= '0;
        end else if (q_rd) begin
            unique case (phase_r)
                apf_pkg::PH_MSB: begin
                    phase_r <= apf_pkg::PH_LSB;
                    hold_r <= q_valid ? q_data : '0;
                end
                apf_pkg::PH_LSB: phase_r <= apf_pkg::PH_GAP;
                apf_pkg::PH_GAP: phase_r <= apf_pkg::PH_MSB;
                default: phase_r <= apf_pkg::PH_MSB;
            endcase
        end else if (access) begin
            phase_r <= apf_pkg::PH_MSB;
        end
    end

    // Burst pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            bptr_r <= 8'h00;
            bfix_r <= 1'b0;
        end else if (wr && (idx == apf_pkg::IDX_BADDR)) begin
            bptr_r <= pwdata[7:0];
            bfix_r <= (pwdata[7:0] == apf_pkg::IDX_QUEUE);
        end else if (rd && (idx == apf_pkg::IDX_BDATA) && !queue_path) begin
            bptr_r <= bptr_r + 8'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_fast_select: assert property (
        wr && (idx == apf_pkg::IDX_POWER) |=> pwr_r.two_wire_fast_select == $past(pwdata[7]))
        else $error("fast select bit not taken");
    a_level_select: assert property (
        wr && (idx == apf_pkg::IDX_POWER) |=> pwr_r.impact_wake_level_select == $past(pwdata[5]))
        else $error("impact level bit not taken");
    a_settle_short: assert property (
        wr && (idx == apf_pkg::IDX_POWER) && wpow.settle_short
        |=> settle_cnt_r == SETTLE_SHORT_LAST && !settled_r)
        else $error("short settle period not loaded");
    a_filter_bypass: assert property (
        wr && (idx == apf_pkg::IDX_POWER)
        |=> {pwr_r.lowpass_bypass, pwr_r.highpass_bypass} == $past(pwdata[3:2]))
        else $error("filter bypass bits not taken");
    a_mode_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> pwr_r.mode == apf_pkg::MODE_STANDBY && tim_r == 2'h0)
        else $error("mode not standby after reset");
    a_check_start: assert property (
        wr && (idx == apf_pkg::IDX_SELF) && pwdata[0] |=> st_go_r && !self_check_complete_r ##1 !st_pass_r)
        else $error("self check did not start");
    a_check_done: assert property (
        $rose(self_check_complete_r) |-> $past(st_cnt_r) == apf_pkg::SC_LAST && $past(st_go_r))
        else $error("self check finished early");
    a_soft_reset: assert property (@(posedge clk) disable iff (srst)
        wr && (idx == apf_pkg::IDX_RESET) && (pwdata[7:0] == apf_pkg::RESET_CODE)
        |=> soft_rst_r ##1 pwr_r == apf_pkg::apf_power_t'(apf_pkg::REG_RST) && !st_go_r)
        else $error("reset code did not reset");
    a_other_code: assert property (
        wr && (idx == apf_pkg::IDX_RESET) && (pwdata[7:0] != apf_pkg::RESET_CODE)
        |=> !soft_rst_r && $stable(pwr_r))
        else $error("wrong code changed state");
    a_third_pop: assert property (
        q_pop |=> !q_pop && phase_r == apf_pkg::PH_LSB)
        else $error("queue popped off phase");
    a_fixed_ptr: assert property (
        rd && (idx == apf_pkg::IDX_BDATA) && bfix_r && (bptr_r == apf_pkg::IDX_QUEUE)
        |=> bptr_r == apf_pkg::IDX_QUEUE)
        else $error("burst pointer moved on queue");
    a_zero_skip: assert property (
        rd && skip_zero |-> !q_pop ##1 prdata_r == '0 && bptr_r == 8'h43)
        else $error("skipped queue read misbehaved");
    a_outside_clock: assert property (
        $rose(pend_r) && $past(outside_clock_enable) && !$past(outside_trigger_enable)
        |-> $past(p1_rise))
        else $error("sample taken without pin one edge");
    a_trig_sample: assert property (
        outside_trigger_enable && p2_rise && settled_r && !pend_r
        && (pwr_r.mode != apf_pkg::MODE_STANDBY) |=> pend_r)
        else $error("trigger produced no sample");
    a_pass_valid: assert property (
        st_pass_r |-> self_check_complete_r)
        else $error("pass shown before completion");

endmodule

// ### verilog/apf_pkg.sv
// Shared constants and types for the accelerometer control register bank.
// Assumes a 200 MHz system clock and APB with 32-bit data, one byte per word.
package apf_pkg;

    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMING = 8'h3D;
    localparam logic [7:0] IDX_POWER = 8'h3F;
    localparam logic [7:0] IDX_SELF = 8'h40;
    localparam logic [7:0] IDX_RESET = 8'h41;
    localparam logic [7:0] IDX_QUEUE = 8'h42;
    localparam logic [7:0] IDX_BADDR = 8'h44;
    localparam logic [7:0] IDX_BDATA = 8'h45;

    // Field positions and codes
    localparam int TIM_XCLK_BIT = 1;
    localparam int TIM_XTRIG_BIT = 0;
    localparam int SC_GO_BIT = 0;
    localparam logic [7:0] RESET_CODE = 8'h52;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] TIM_RST = 2'h0;

    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_LONG_MS = 370;
    localparam int SETTLE_SHORT_MS = 16;
    localparam int SETTLE_LONG_CYC = SETTLE_LONG_MS * CLK_MHZ * 1000;
    localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CLK_MHZ * 1000;
    localparam int SETTLE_W = 27;
    localparam int TICK_CYC = 500000;
    localparam int TICK_W = 19;
    localparam int SELF_CHECK_CYC = 64;
    localparam logic [6:0] SC_LAST = 7'(SELF_CHECK_CYC - 1);

    // Sample queue
    localparam int SAMPLE_W = 16;
    localparam int QUEUE_DEPTH = 4;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_WAKE = 2'b01,
        MODE_IMPACT = 2'b10,
        MODE_FULL = 2'b11
    } apf_mode_t;

    typedef enum logic [1:0] {
        PH_MSB = 2'b00,
        PH_LSB = 2'b01,
        PH_GAP = 2'b10
    } apf_phase_t;

    typedef struct packed {
        logic two_wire_fast_select;
        logic rsvd;
        logic impact_wake_level_select;
        logic settle_short;
        logic lowpass_bypass;
        logic highpass_bypass;
        apf_mode_t mode;
    } apf_power_t;

    typedef struct packed {
        logic self_check_pass;
        logic self_check_complete;
        logic self_check_go;
    } apf_check_t;

endpackage

// ### verilog/apf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset is synchronous and active high.
`timescale 1ns/1ps
module apf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CFULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign pop = out_ready & out_valid;
    assign out_data = mem[rptr_r];

    always_comb begin
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == PLAST) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == PLAST) ? '0 : rptr_r + 1'b1;
            end
        end
    end

    // Flags registered from the next count
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != CFULL);
            out_valid <= (cnt_nxt != '0);
        end
    end

endmodule

// ### verification/apf_sensor_model.sv
// Sensor front end model: pulses the trigger pin and supplies samples.
// Assumes one clock shared with the register bank; srst is synchronous.
`timescale 1ns/1ps
module apf_sensor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request from the bench
    input wire logic fire,
    // Pin and sample toward the bank
    output logic irq_pin_two,
    output logic [15:0] adc_sample
);
    logic [3:0] cnt_r;
    logic [7:0] n_r;
    // Pin held high 8 cycles, sample steps when it falls
    always @(posedge clk) begin
        if (srst) begin
            cnt_r <= 4'h0;
            n_r <= 8'h00;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r == 4'h8) begin
                n_r <= n_r + 8'h01;
            end
        end else if (fire) begin
            cnt_r <= 4'h1;
        end
    end
    assign irq_pin_two = (cnt_r != 4'h0);
    assign adc_sample = 16'h1234 + 16'(n_r) * 16'h0101;
endmodule

// ### verification/testbench.sv
// Self-checking bench for the register bank, acting as APB master.
// Assumes the sensor model above and shortened settle and tick counts.
`timescale 1ns/1ps
module testbench;
    logic clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic irq_pin_two, self_check_ok, fire, oce, ote, settled, dropped;
    logic pin1;
    logic [15:0] adc_sample;
    apf_pkg::apf_power_t power_and_mode_control;
    apf_pkg::apf_check_t st;
    logic [7:0] r;
    logic e;
    int errors = 0;
    int compares = 0;
    logic [23:0] rows [13] = '{
        24'h3FFFBF, 24'h3F8080, 24'h3F2020, 24'h3F1010, 24'h3F0808,
        24'h3F0404, 24'h3F0101, 24'h3F0202, 24'h3F0303, 24'h3F0000,
        24'h3DFF03, 24'h3D0202, 24'h3D0000};

    apf_ctrl #(.SETTLE_LONG_CYC(40), .SETTLE_SHORT_CYC(10), .TICK_CYC(20)) i_apf_ctrl (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pin_one(pin1), .irq_pin_two(irq_pin_two),
        .adc_sample(adc_sample), .self_check_ok(self_check_ok), .power_and_mode_control(power_and_mode_control),
        .outside_clock_enable(oce), .outside_trigger_enable(ote),
        .filter_settled(settled), .self_check_status(st), .sample_dropped(dropped));
    apf_sensor_model i_apf_sensor_model (
        .clk(clk), .srst(srst), .fire(fire), .irq_pin_two(irq_pin_two),
        .adc_sample(adc_sample));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(8'h00, 8'hFF);
        end
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(r, exp);
    endtask

    task automatic pulse();
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (16) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, fire, self_check_ok, pin1} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rdc(8'h3F, 8'h00);
        rdc(8'h40, 8'h00);
        rdc(8'h3D, 8'h00);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
            chk(rows[i][23:16] == 8'h3F ? power_and_mode_control : {6'h0, oce, ote}, rows[i][7:0]);
        end
        apb(1'b0, 8'h50, 8'h00);
        chk({7'h0, e}, 8'h01);
        chk(r, 8'h00);
        self_check_ok <= 1'b1;
        apb(1'b1, 8'h40, 8'h01);
        rdc(8'h40, 8'h01);
        repeat (70) @(posedge clk);
        rdc(8'h40, 8'h07);
        chk({5'h00, st}, 8'h07);
        apb(1'b1, 8'h40, 8'h06);
        rdc(8'h40, 8'h06);
        apb(1'b1, 8'h3D, 8'h01);
        apb(1'b1, 8'h3F, 8'h13);
        chk({7'h0, settled}, 8'h00);
        repeat (20) @(posedge clk);
        chk({7'h0, settled}, 8'h01);
        for (int k = 0; k < 6; k++) begin
            pulse();
        end
        chk({7'h0, dropped}, 8'h01);
        for (int k = 0; k < 5; k++) begin
            rdc(8'h42, 8'h12 + 8'(k));
            rdc(8'h42, 8'h34 + 8'(k));
            rdc(8'h42, 8'h00);
        end
        rdc(8'h42, 8'h00);
        pulse();
        apb(1'b1, 8'h44, 8'h41);
        rdc(8'h45, 8'h00);
        rdc(8'h45, 8'h00);
        rdc(8'h44, 8'h43);
        apb(1'b1, 8'h44, 8'h42);
        rdc(8'h45, 8'h18);
        rdc(8'h44, 8'h42);
        rdc(8'h41, 8'h00);
        apb(1'b1, 8'h41, 8'h11);
        rdc(8'h3F, 8'h13);
        apb(1'b1, 8'h41, 8'h52);
        repeat (3) @(posedge clk);
        rdc(8'h3F, 8'h00);
        rdc(8'h3D, 8'h00);
        chk({7'h0, dropped}, 8'h00);
        // Failing self check leaves pass low
        self_check_ok <= 1'b0;
        apb(1'b1, 8'h40, 8'h01);
        repeat (70) @(posedge clk);
        rdc(8'h40, 8'h03);
        chk({5'h00, st}, 8'h03);
        // Outside clock on pin one, long settle
        apb(1'b1, 8'h3D, 8'h02);
        apb(1'b1, 8'h3F, 8'h03);
        repeat (30) @(posedge clk);
        chk({7'h0, settled}, 8'h00);
        repeat (15) @(posedge clk);
        chk({7'h0, settled}, 8'h01);
        repeat (60) @(posedge clk);
        rdc(8'h42, 8'h00);
        rdc(8'h3D, 8'h02);
        pin1 <= 1'b1;
        repeat (4) @(posedge clk);
        pin1 <= 1'b0;
        repeat (8) @(posedge clk);
        rdc(8'h42, 8'h19);
        rdc(8'h42, 8'h3B);
        rdc(8'h42, 8'h00);
        // Internal divider takes over again
        apb(1'b1, 8'h3D, 8'h00);
        repeat (60) @(posedge clk);
        rdc(8'h42, 8'h19);
        close_out();
    end
endmodule
